// >>> design/sspd_ctrl.sv
/*
 * sspd_ctrl: power-down filtering, power-on reset sequencing, strap capture,
 * serial pin role selection and image revision readback.
 * Assumes pin inputs other than power_down_n are synchronous to clock; supply and pin threshold
 * comparators arrive as level flags from analog.
 */
`timescale 1ns/1ps
module sspd_ctrl #(
    parameter int POR_CYCLES = sspd_pkg::POR_DELAY_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       power_down_n,
    input  wire logic       supplies_good,
    input  wire logic       pd_above_vih,
    input  wire logic       soft_reset,
    input  wire logic       interface_select_strap,
    input  wire logic [1:0] page_strap_low,
    input  wire logic [1:0] page_strap_high,
    input  wire logic       shadow_wr_en,
    input  wire logic [4:0] shadow_wr_addr,
    input  wire logic [7:0] shadow_wr_data,
    input  wire logic       image_program,
    input  wire logic [7:0] reg_rd_index,
    output logic [7:0]      reg_rd_data,
    output logic            device_reset_n,
    output logic            calibrate_start,
    output logic            spi_mode,
    output logic            use_eeprom_image,
    output logic [1:0]      rom_page_low,
    output logic [1:0]      rom_page_high,
    output logic            select_three_level,
    output logic            serial_enable,
    output logic            data_pin_oe_n,
    output logic            strap_pins_gpio
);
    sspd_mem_if mem_bus ();

    sspd_image_mem u_mem (
        .clock (clock),
        .rst_n (rst_n),
        .port  (mem_bus.mem)
    );

    // power-down synchroniser; first stage feeds only the second
    logic pd_meta;
    logic pd_sync;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
        end else begin
            pd_meta <= power_down_n;
            pd_sync <= pd_meta;
        end
    end

    // low-pulse filter: short glitches below the minimum width are not a reset
    logic [7:0] pd_low_cnt;
    logic [7:0] next_pd_low_cnt;
    logic       pd_down;
    logic       next_pd_down;
    always_comb begin
        next_pd_low_cnt = pd_low_cnt;
        next_pd_down    = pd_down;
        if (pd_sync) begin
            next_pd_low_cnt = 8'h00;
            next_pd_down    = 1'b0;
        end else if (pd_low_cnt >= 8'(sspd_pkg::PD_FILTER_CYCLES - 1)) begin
            next_pd_down    = 1'b1;
        end else begin
            next_pd_low_cnt = pd_low_cnt + 8'h01;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pd_low_cnt <= 8'h00;
            pd_down    <= 1'b1;
        end else begin
            pd_low_cnt <= next_pd_low_cnt;
            pd_down    <= next_pd_down;
        end
    end

    // start-up sequencer
    sspd_pkg::sspd_state_t state;
    sspd_pkg::sspd_state_t next_state;
    logic [15:0] por_cnt;
    logic [15:0] next_por_cnt;
    logic        pwr_ok;
    assign pwr_ok = supplies_good && pd_above_vih;

    always_comb begin
        next_state   = state;
        next_por_cnt = por_cnt;
        if (pd_down || !supplies_good) begin
            next_state   = sspd_pkg::SSPD_ST_DOWN;
            next_por_cnt = 16'h0000;
        end else begin
            case (state)
                sspd_pkg::SSPD_ST_DOWN: begin
                    // pin level gates the exit only; a short glitch must not drop a running device
                    if (pwr_ok) begin
                        next_state = sspd_pkg::SSPD_ST_POR;
                    end
                    next_por_cnt = 16'h0000;
                end
                sspd_pkg::SSPD_ST_POR: begin
                    if (por_cnt >= 16'(POR_CYCLES - 1)) begin
                        next_state = sspd_pkg::SSPD_ST_LATCH;
                    end else begin
                        next_por_cnt = por_cnt + 16'h0001;
                    end
                end
                sspd_pkg::SSPD_ST_LATCH: next_state = sspd_pkg::SSPD_ST_RUN;
                sspd_pkg::SSPD_ST_RUN:   next_state = sspd_pkg::SSPD_ST_RUN;
                default:                 next_state = sspd_pkg::SSPD_ST_DOWN;
            endcase
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state   <= sspd_pkg::SSPD_ST_DOWN;
            por_cnt <= 16'h0000;
        end else begin
            state   <= next_state;
            por_cnt <= next_por_cnt;
        end
    end

    // strap capture happens once in the latch state and holds, through any down, until the next latch
    logic       next_spi_mode;
    logic       next_use_eeprom;
    logic [1:0] next_page_low;
    logic [1:0] next_page_high;
    logic       latching;
    assign latching = (state == sspd_pkg::SSPD_ST_LATCH);
    always_comb begin
        next_spi_mode   = spi_mode;
        next_use_eeprom = use_eeprom_image;
        next_page_low   = rom_page_low;
        next_page_high  = rom_page_high;
        if (latching) begin
            next_spi_mode   = interface_select_strap;
            next_page_low   = page_strap_low;
            next_page_high  = page_strap_high;
            // both straps mid picks the eeprom image instead of a rom page
            next_use_eeprom = (page_strap_low == sspd_pkg::SSPD_LVL_MID) &&
                              (page_strap_high == sspd_pkg::SSPD_LVL_MID);
        end
    end

    // serial pin roles and reset/calibration outputs, all registered
    logic running;
    logic next_cal;
    assign running = (next_state == sspd_pkg::SSPD_ST_RUN);
    // soft reset only restarts calibration once supplies are stable
    assign next_cal = (latching && next_state == sspd_pkg::SSPD_ST_RUN) ||
                      (state == sspd_pkg::SSPD_ST_RUN && soft_reset);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spi_mode           <= 1'b0;
            use_eeprom_image   <= 1'b0;
            rom_page_low       <= 2'b00;
            rom_page_high      <= 2'b00;
            device_reset_n     <= 1'b0;
            calibrate_start    <= 1'b0;
            select_three_level <= 1'b1;
            serial_enable      <= 1'b0;
            data_pin_oe_n      <= 1'b1;
            strap_pins_gpio    <= 1'b0;
        end else begin
            spi_mode           <= next_spi_mode;
            use_eeprom_image   <= next_use_eeprom;
            rom_page_low       <= next_page_low;
            rom_page_high      <= next_page_high;
            device_reset_n     <= running;
            calibrate_start    <= next_cal;
            select_three_level <= running ? !next_spi_mode : 1'b1;
            serial_enable      <= running;
            data_pin_oe_n      <= 1'b1;
            strap_pins_gpio    <= running;
        end
    end

    // shadow write path only; no active register write reaches the revision byte
    assign mem_bus.wr_en   = shadow_wr_en && (state == sspd_pkg::SSPD_ST_RUN);
    assign mem_bus.wr_addr = shadow_wr_addr;
    assign mem_bus.wr_data = shadow_wr_data;
    assign mem_bus.rd_addr = sspd_pkg::IMAGE_REV_BYTE_ADR[4:0];

    // revision in use is copied from the image on programming or at start-up
    logic [7:0] rev_in_use;
    logic [7:0] next_rev_in_use;
    logic       load_q;
    always_comb begin
        next_rev_in_use = rev_in_use;
        if (load_q) begin
            next_rev_in_use = mem_bus.rd_data;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rev_in_use  <= sspd_pkg::IMAGE_REV_RESET;
            load_q      <= 1'b0;
            reg_rd_data <= 8'h00;
        end else begin
            rev_in_use  <= next_rev_in_use;
            load_q      <= latching || (image_program && state == sspd_pkg::SSPD_ST_RUN);
            // readback register at index 19; other indexes read zero here
            reg_rd_data <= (reg_rd_index == sspd_pkg::REG_IMAGE_REV_IDX && running) ?
                           next_rev_in_use : 8'h00;
        end
    end

    sequence s_pd_gone;
        !pd_sync [*8];
    endsequence
    a_down_holds_reset: assert property (@(posedge clock) disable iff (!rst_n)
        s_pd_gone |-> ##2 !device_reset_n && !serial_enable)
        else $error("device left reset while power-down held low");
    a_por_after_rise: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(pd_sync) && state == sspd_pkg::SSPD_ST_DOWN && pwr_ok
        |-> ##2 state == sspd_pkg::SSPD_ST_POR)
        else $error("power-on sequence did not start");
    a_supply_gate: assert property (@(posedge clock) disable iff (!rst_n)
        !supplies_good |=> state == sspd_pkg::SSPD_ST_DOWN)
        else $error("sequencer ran without good supplies");
    a_pin_gate: assert property (@(posedge clock) disable iff (!rst_n)
        state == sspd_pkg::SSPD_ST_DOWN && !pd_above_vih
        |=> state == sspd_pkg::SSPD_ST_DOWN)
        else $error("sequencer left power-down with pin below threshold");
    a_strap_spi: assert property (@(posedge clock) disable iff (!rst_n)
        latching |=> spi_mode == $past(interface_select_strap))
        else $error("interface strap not captured");
    a_strap_hold: assert property (@(posedge clock) disable iff (!rst_n)
        state == sspd_pkg::SSPD_ST_RUN && $past(state) == sspd_pkg::SSPD_ST_RUN
        |-> $stable(spi_mode) && $stable(rom_page_low))
        else $error("strap values changed after start-up");
    a_select_role: assert property (@(posedge clock) disable iff (!rst_n)
        device_reset_n |-> select_three_level == !spi_mode)
        else $error("select pin role mismatches interface");
    a_data_pin_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        !device_reset_n |-> data_pin_oe_n && !strap_pins_gpio)
        else $error("pins driven during reset");
    a_rev_readback: assert property (@(posedge clock) disable iff (!rst_n)
        running && reg_rd_index == sspd_pkg::REG_IMAGE_REV_IDX && !load_q
        |=> reg_rd_data == rev_in_use)
        else $error("revision readback wrong");
    a_no_stray_rev: assert property (@(posedge clock) disable iff (!rst_n)
        !load_q |=> $stable(rev_in_use))
        else $error("revision changed without image load");
endmodule : sspd_ctrl

// >>> design/sspd_pkg.sv
/*
 * sspd_pkg: constants shared by the start-up strap and power-down control block.
 * Assumes a single 40 MHz system clock domain.
 */
package sspd_pkg;
    localparam int          CLK_PERIOD_NS       = 25;
    localparam int          PD_MIN_PULSE_NS     = 200;
    // power-down low must persist at least this many cycles to count as a hard reset
    localparam int          PD_FILTER_CYCLES    = (PD_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          POR_DELAY_CYCLES    = 16;
    localparam logic [7:0]  REG_IMAGE_REV_IDX   = 8'h13;
    localparam logic [12:0] IMAGE_REV_BYTE_ADR  = 13'h000d;
    localparam int          IMAGE_DEPTH         = 32;
    localparam int          IMAGE_ADDR_W        = 5;
    localparam logic [7:0]  IMAGE_REV_RESET     = 8'h00;

    // three-level strap coding
    typedef enum logic [1:0] {
        SSPD_LVL_LOW  = 2'b00,
        SSPD_LVL_MID  = 2'b01,
        SSPD_LVL_HIGH = 2'b11
    } sspd_level_t;

    // start-up sequencer states, gray along the usual path
    typedef enum logic [1:0] {
        SSPD_ST_DOWN  = 2'b00,
        SSPD_ST_POR   = 2'b01,
        SSPD_ST_LATCH = 2'b11,
        SSPD_ST_RUN   = 2'b10
    } sspd_state_t;
endpackage : sspd_pkg

// >>> design/sspd_mem_if.sv
/*
 * sspd_mem_if: port group between the controller and the image memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface sspd_mem_if;
    logic       wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : sspd_mem_if

// >>> design/sspd_image_mem.sv
/*
 * sspd_image_mem: small shadow image memory with registered read data.
 * Assumes writes only come from the shadow-programming port of the controller.
 */
`timescale 1ns/1ps
module sspd_image_mem #(
    parameter int DEPTH = sspd_pkg::IMAGE_DEPTH
) (
    input  wire logic clock,
    input  wire logic rst_n,
    sspd_mem_if.mem   port
);
    logic [7:0] store [DEPTH];
    logic [7:0] rd_q;

    // shadow copy clears on reset so a blank image reads zero, never unknown
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                store[i] <= 8'h00;
            end
        end else if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= store[port.rd_addr];
        end
    end
    assign port.rd_data = rd_q;
endmodule : sspd_image_mem

// >>> dv/sspd_host_model.sv
/*
 * sspd_host_model: system host that owns the power-down pin and watches the supplies.
 * Assumes the bench sets want_run, supply_on, glitch and early off the clock edge.
 */
`timescale 1ns/1ps
module sspd_host_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic want_run,
    input  wire logic supply_on,
    input  wire logic glitch,
    input  wire logic early,
    output logic      power_down_n,
    output logic      supplies_good,
    output logic      pd_above_vih
);
    logic [3:0] low_cnt;
    logic [3:0] settle;
    logic [2:0] glitch_left;

    // comparator flags follow the rails and the pin level directly
    assign supplies_good = supply_on;
    assign pd_above_vih  = power_down_n;

    // pin is released only after a long low and settled supplies, unless told to misbehave
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_down_n <= 1'b0;
            low_cnt      <= 4'h0;
            settle       <= 4'h0;
            glitch_left  <= 3'h0;
        end else begin
            settle <= !supply_on ? 4'h0 : (settle == 4'hf ? settle : settle + 4'h1);
            if (glitch) begin
                glitch_left  <= 3'h4;
                power_down_n <= 1'b0;
            end else if (glitch_left != 3'h0) begin
                glitch_left  <= glitch_left - 3'h1;
                power_down_n <= (glitch_left == 3'h1);
            end else if (!want_run) begin
                power_down_n <= 1'b0;
                low_cnt      <= 4'h0;
            end else begin
                low_cnt <= (low_cnt == 4'hf) ? low_cnt : low_cnt + 4'h1;
                if ((low_cnt >= 4'h9 && settle >= 4'h4) || early) begin
                    power_down_n <= 1'b1;
                end
            end
        end
    end
endmodule : sspd_host_model

// >>> dv/test_startup_strap_and_power_down_control.sv
/*
 * test_startup_strap_and_power_down_control: directed bench for sspd_ctrl.
 * Assumes a short power-on delay parameter and a host model on the power-down pin.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module test_startup_strap_and_power_down_control;
    logic       clock = 1'b0, rst_n = 1'b0, want_run = 1'b0, supply_on = 1'b0;
    logic       glitch = 1'b0, early = 1'b0, soft_reset = 1'b0, interface_select_strap = 1'b1;
    logic       shadow_wr_en = 1'b0, image_program = 1'b0;
    logic [1:0] page_strap_low = 2'b00, page_strap_high = 2'b11;
    logic [4:0] shadow_wr_addr = 5'h00;
    logic [7:0] shadow_wr_data = 8'h00, reg_rd_index = 8'h00, reg_rd_data;
    logic       power_down_n, supplies_good, pd_above_vih, device_reset_n, calibrate_start;
    logic       spi_mode, use_eeprom_image, select_three_level, serial_enable;
    logic       data_pin_oe_n, strap_pins_gpio;
    logic [1:0] rom_page_low, rom_page_high;
    int         error_cnt = 0, tests_run = 0, cycles = 0;

    sspd_host_model host (.clock(clock), .rst_n(rst_n), .want_run(want_run),
        .supply_on(supply_on), .glitch(glitch), .early(early), .power_down_n(power_down_n),
        .supplies_good(supplies_good), .pd_above_vih(pd_above_vih));

    sspd_ctrl #(.POR_CYCLES(2)) uut (.clock(clock), .rst_n(rst_n),
        .power_down_n(power_down_n), .supplies_good(supplies_good),
        .pd_above_vih(pd_above_vih), .soft_reset(soft_reset),
        .interface_select_strap(interface_select_strap), .page_strap_low(page_strap_low),
        .page_strap_high(page_strap_high), .shadow_wr_en(shadow_wr_en),
        .shadow_wr_addr(shadow_wr_addr), .shadow_wr_data(shadow_wr_data),
        .image_program(image_program), .reg_rd_index(reg_rd_index),
        .reg_rd_data(reg_rd_data), .device_reset_n(device_reset_n),
        .calibrate_start(calibrate_start), .spi_mode(spi_mode),
        .use_eeprom_image(use_eeprom_image), .rom_page_low(rom_page_low),
        .rom_page_high(rom_page_high), .select_three_level(select_three_level),
        .serial_enable(serial_enable), .data_pin_oe_n(data_pin_oe_n),
        .strap_pins_gpio(strap_pins_gpio));

    // 40 MHz system clock
    always #12.5 clock = ~clock;

    task automatic end_sim();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // a hang anywhere counts as a mismatch; whole run needs well under 2000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    // inputs always move 2 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick

    // registered read port answers one cycle after the index
    task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
        reg_rd_index = idx;
        tick(1);
        `CHK(reg_rd_data, exp)
    endtask : rd_check

    task automatic shadow_write(input logic [7:0] data);
        shadow_wr_en   = 1'b1;
        shadow_wr_addr = 5'h0d;
        shadow_wr_data = data;
        tick(1);
        shadow_wr_en = 1'b0;
    endtask : shadow_write

    task automatic bring_up();
        want_run = 1'b1;
        for (int i = 0; i < 60 && device_reset_n !== 1'b1; i++) tick(1);
        `CHK(device_reset_n, 1'b1)
        `CHK(calibrate_start, 1'b1)
        `CHK(serial_enable, 1'b1)
        tick(1);
        `CHK(calibrate_start, 1'b0)
    endtask : bring_up

    task automatic go_down();
        want_run = 1'b0;
        tick(12);
        `CHK(device_reset_n, 1'b0)
        `CHK(serial_enable, 1'b0)
        `CHK(data_pin_oe_n, 1'b1)
        `CHK(strap_pins_gpio, 1'b0)
        `CHK(select_three_level, 1'b1)
    endtask : go_down

    // supplies low with the pin forced high early: device must stay in reset
    task automatic t_supply_hold();
        early    = 1'b1;
        want_run = 1'b1;
        tick(30);
        `CHK(device_reset_n, 1'b0)
        `CHK(calibrate_start, 1'b0)
        early     = 1'b0;
        want_run  = 1'b0;
        // pin must fall before the rails come up, else a stray start slips through
        tick(2);
        supply_on = 1'b1;
        tick(3);
    endtask : t_supply_hold

    // spi strap, low and high rom pages; straps moved afterwards must not matter
    task automatic t_spi_start();
        bring_up();
        `CHK(spi_mode, 1'b1)
        `CHK(select_three_level, 1'b0)
        `CHK({rom_page_high, rom_page_low}, 4'hc)
        `CHK(use_eeprom_image, 1'b0)
        `CHK(strap_pins_gpio, 1'b1)
        interface_select_strap = 1'b0;
        page_strap_low         = 2'b01;
        tick(4);
        `CHK(spi_mode, 1'b1)
        `CHK(rom_page_low, 2'b00)
    endtask : t_spi_start

    // revision only moves with shadow write plus image programming
    task automatic t_revision();
        rd_check(8'h13, 8'h00);
        shadow_write(8'h5a);
        tick(3);
        rd_check(8'h13, 8'h00);
        image_program = 1'b1;
        tick(1);
        image_program = 1'b0;
        tick(3);
        rd_check(8'h13, 8'h5a);
        rd_check(8'h12, 8'h00);
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        `CHK(calibrate_start, 1'b1)
    endtask : t_revision

    // a 4-cycle low is filtered, a long low is a hard reset
    task automatic t_pulses();
        glitch = 1'b1;
        tick(1);
        glitch = 1'b0;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            `CHK(device_reset_n, 1'b1)
        end
        go_down();
        rd_check(8'h13, 8'h00);
    endtask : t_pulses

    // i2c strap with both pages mid; write while down is refused, revision reloads
    task automatic t_i2c_start();
        interface_select_strap = 1'b0;
        page_strap_low         = 2'b01;
        page_strap_high        = 2'b01;
        shadow_write(8'ha5);
        bring_up();
        `CHK(spi_mode, 1'b0)
        `CHK(select_three_level, 1'b1)
        `CHK(use_eeprom_image, 1'b1)
        `CHK({rom_page_high, rom_page_low}, 4'h5)
        tick(3);
        rd_check(8'h13, 8'h5a);
    endtask : t_i2c_start

    initial begin
        tick(4);
        `CHK(data_pin_oe_n, 1'b1)
        `CHK(device_reset_n, 1'b0)
        rst_n = 1'b1;
        t_supply_hold();
        t_spi_start();
        t_revision();
        t_pulses();
        t_i2c_start();
        end_sim();
    end
endmodule : test_startup_strap_and_power_down_control
